// file: hdl/rdc_cfg.svh
// Offsets, field positions and power-up values of the configuration bytes
`ifndef RDC_CFG_SVH
`define RDC_CFG_SVH

// Byte offsets
`define RDC_OFS_SECOND_PAIR   8'h0A
`define RDC_OFS_FIRST_PAIR    8'h0B
`define RDC_OFS_THRESH_CTRL   8'h0C
`define RDC_OFS_RSVD_FIRST    8'h0D
`define RDC_OFS_RSVD_LAST     8'h1F

// Power-up values
`define RDC_RST_SECOND_PAIR   8'hFC
`define RDC_RST_FIRST_PAIR    8'hFC
`define RDC_RST_THRESH_CTRL   8'h58

// Control byte field positions
`define RDC_THR_MSB           7
`define RDC_THR_LSB           6
`define RDC_HPD_EN_N_BIT      2
`define RDC_AUX_EN_N_BIT      1

// Threshold codes
`define RDC_THR_50MV          2'h0
`define RDC_THR_65MV          2'h1
`define RDC_THR_80MV          2'h2
`define RDC_THR_95MV          2'h3

// Serial port
`define RDC_DEV_ADDR_DEFAULT  7'h2A
`define RDC_BITS_PER_BYTE     4'h8
`define RDC_READ_FILL         8'h00

`endif

// file: hdl/rdc_cfg_byte.sv
// One read/write configuration byte with its own power-up value
`timescale 1ns/1ns
module rdc_cfg_byte #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_b,
  // Write port
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  // Stored value
  output logic [7:0]      q
);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      q <= RESET_VAL;
    end else if (wr_en) begin
      q <= wr_data;
    end
  end

endmodule

// file: hdl/rdc_pkg.sv
// Types shared by the configuration byte bank
package rdc_pkg;

  typedef struct packed {
    logic [1:0] signal_detect_threshold;
    logic       rsvd5;
    logic       rsvd4;
    logic       rsvd3;
    logic       hotplug_pin_enable_n;
    logic       aux_mux_enable_n;
    logic       rsvd0;
  } rdc_ctrl_type;

  typedef enum logic [2:0] {
    RDC_IDLE,
    RDC_ADDR,
    RDC_ADDR_ACK,
    RDC_WDATA,
    RDC_WACK,
    RDC_RDATA,
    RDC_RACK
  } rdc_state_type;

endpackage

// file: hdl/rdc_regs.sv
// Serial slave port and upper configuration bytes of the redriver
`timescale 1ns/1ns
`include "rdc_cfg.svh"

module rdc_regs
  import rdc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `RDC_DEV_ADDR_DEFAULT
) (
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   rst_b,
  // Serial port
  input  wire logic   scl,
  input  wire logic   sda_in,
  output logic        sda_out,
  output logic        sda_oe,
  // Hot-plug pin
  input  wire logic   hotplug_input_pin,
  output logic        hotplug_level,
  // Configuration outputs
  output logic [7:0]  second_connector_pair,
  output logic [7:0]  first_connector_pair,
  output rdc_ctrl_type ctrl,
  output logic        aux_mux_enable
);

  logic          scl_q;
  logic          sda_q;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_det;
  logic          stop_det;
  rdc_state_type state_r;
  logic [3:0]    bit_cnt_r;
  logic [7:0]    rx_r;
  logic [7:0]    tx_r;
  logic [7:0]    ptr_r;
  logic          rw_r;
  logic          first_r;
  logic          nack_r;
  logic [7:0]    rd_byte;
  logic [7:0]    ctrl_q;
  logic          byte_done;
  logic          wr_strobe;
  logic          wr_second;
  logic          wr_first;
  logic          wr_ctrl;

  // Line edge and bus condition detection
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  assign scl_rise  = scl & ~scl_q;
  assign scl_fall  = ~scl & scl_q;
  assign start_det = scl & scl_q & sda_q & ~sda_in;
  assign stop_det  = scl & scl_q & ~sda_q & sda_in;
  assign byte_done = scl_fall && (bit_cnt_r == `RDC_BITS_PER_BYTE);

  // Read data selection
  always_comb begin
    if (ptr_r == `RDC_OFS_SECOND_PAIR) begin
      rd_byte = second_connector_pair;
    end else if (ptr_r == `RDC_OFS_FIRST_PAIR) begin
      rd_byte = first_connector_pair;
    end else if (ptr_r == `RDC_OFS_THRESH_CTRL) begin
      rd_byte = ctrl_q;
    end else begin
      rd_byte = `RDC_READ_FILL;
    end
  end

  // Byte write strobes
  assign wr_strobe = byte_done && (state_r == RDC_WDATA) && !first_r;
  assign wr_second = wr_strobe && (ptr_r == `RDC_OFS_SECOND_PAIR);
  assign wr_first  = wr_strobe && (ptr_r == `RDC_OFS_FIRST_PAIR);
  assign wr_ctrl   = wr_strobe && (ptr_r == `RDC_OFS_THRESH_CTRL);

  // Bit counter and receive shifter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_r <= 4'h0;
      rx_r      <= 8'h00;
    end else if (start_det) begin
      bit_cnt_r <= 4'h0;
    end else if (scl_rise && (state_r == RDC_ADDR || state_r == RDC_WDATA ||
                              state_r == RDC_RDATA)) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      rx_r      <= {rx_r[6:0], sda_in};
    end else if (scl_fall && (state_r == RDC_ADDR_ACK || state_r == RDC_WACK ||
                              state_r == RDC_RACK)) begin
      bit_cnt_r <= 4'h0;
    end
  end

  // Master acknowledge capture during reads
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      nack_r <= 1'b0;
    end else if (scl_rise && state_r == RDC_RACK) begin
      nack_r <= sda_in;
    end
  end

  // Transfer sequencer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= RDC_IDLE;
      sda_oe  <= 1'b0;
      sda_out <= 1'b0;
      tx_r    <= 8'h00;
      ptr_r   <= 8'h00;
      rw_r    <= 1'b0;
      first_r <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      if (start_det) begin
        state_r <= RDC_ADDR;
        sda_oe  <= 1'b0;
      end else if (stop_det) begin
        state_r <= RDC_IDLE;
        sda_oe  <= 1'b0;
      end else if (scl_fall) begin
        case (state_r)
          RDC_ADDR: begin
            if (byte_done) begin
              if (rx_r[7:1] == DEV_ADDR) begin
                rw_r    <= rx_r[0];
                sda_oe  <= 1'b1;
                state_r <= RDC_ADDR_ACK;
              end else begin
                state_r <= RDC_IDLE;
              end
            end
          end
          RDC_ADDR_ACK: begin
            if (rw_r) begin
              tx_r    <= rd_byte;
              sda_oe  <= ~rd_byte[7];
              ptr_r   <= ptr_r + 8'h01;
              state_r <= RDC_RDATA;
            end else begin
              sda_oe  <= 1'b0;
              first_r <= 1'b1;
              state_r <= RDC_WDATA;
            end
          end
          RDC_WDATA: begin
            if (byte_done) begin
              if (first_r) begin
                ptr_r <= rx_r;
              end else begin
                ptr_r <= ptr_r + 8'h01;
              end
              first_r <= 1'b0;
              sda_oe  <= 1'b1;
              state_r <= RDC_WACK;
            end
          end
          RDC_WACK: begin
            sda_oe  <= 1'b0;
            state_r <= RDC_WDATA;
          end
          RDC_RDATA: begin
            if (byte_done) begin
              sda_oe  <= 1'b0;
              state_r <= RDC_RACK;
            end else begin
              tx_r   <= {tx_r[6:0], 1'b0};
              sda_oe <= ~tx_r[6];
            end
          end
          RDC_RACK: begin
            if (nack_r) begin
              sda_oe  <= 1'b0;
              state_r <= RDC_IDLE;
            end else begin
              tx_r    <= rd_byte;
              sda_oe  <= ~rd_byte[7];
              ptr_r   <= ptr_r + 8'h01;
              state_r <= RDC_RDATA;
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Configuration byte storage
  rdc_cfg_byte #(.RESET_VAL(`RDC_RST_SECOND_PAIR)) u_second_pair (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .wr_en   (wr_second),
    .wr_data (rx_r),
    .q       (second_connector_pair)
  );

  rdc_cfg_byte #(.RESET_VAL(`RDC_RST_FIRST_PAIR)) u_first_pair (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .wr_en   (wr_first),
    .wr_data (rx_r),
    .q       (first_connector_pair)
  );

  rdc_cfg_byte #(.RESET_VAL(`RDC_RST_THRESH_CTRL)) u_thresh_ctrl (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .wr_en   (wr_ctrl),
    .wr_data (rx_r),
    .q       (ctrl_q)
  );

  assign ctrl = rdc_ctrl_type'(ctrl_q);

  // Hot-plug gating and multiplexer enable
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      hotplug_level  <= 1'b0;
      aux_mux_enable <= 1'b0;
    end else begin
      hotplug_level  <= ctrl_q[`RDC_HPD_EN_N_BIT] ? 1'b0 : hotplug_input_pin;
      aux_mux_enable <= ~ctrl_q[`RDC_AUX_EN_N_BIT];
    end
  end

endmodule

// file: sim/rdc_host.sv
// Serial host model driving the configuration port
`timescale 1ns/1ns
module rdc_host (
  // Clock
  input wire logic mclk,
  // Serial lines
  input wire logic sda,
  output logic     scl,
  output logic     sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic drive(input logic c, input logic l);
    scl = c;
    sda_low = l;
    repeat (4) @(negedge mclk);
  endtask
  task automatic start();
    drive(1'b0, 1'b0);
    drive(1'b1, 1'b0);
    drive(1'b1, 1'b1);
    drive(1'b0, 1'b1);
  endtask
  task automatic stop();
    drive(1'b0, 1'b1);
    drive(1'b1, 1'b1);
    drive(1'b1, 1'b0);
  endtask
  task automatic clk_bit(input logic b, output logic r);
    drive(1'b0, !b);
    drive(1'b1, !b);
    r = sda;
    drive(1'b0, !b);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
    clk_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
    clk_bit(last, r);
  endtask
endmodule

// file: sim/rdc_regs_assertions.sv
// Port checks of the configuration byte bank
`timescale 1ns/1ns
module rdc_regs_assertions
  import rdc_pkg::*;
(
  // Clock and reset
  input wire logic         mclk,
  input wire logic         rst_b,
  // Serial port
  input wire logic         scl,
  input wire logic         sda_in,
  input wire logic         sda_out,
  input wire logic         sda_oe,
  // Hot-plug pin
  input wire logic         hotplug_input_pin,
  input wire logic         hotplug_level,
  // Configuration outputs
  input wire logic [7:0]   second_connector_pair,
  input wire logic [7:0]   first_connector_pair,
  input wire rdc_ctrl_type ctrl,
  input wire logic         aux_mux_enable
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_ack;
    $rose(sda_oe);
  endsequence
  sequence s_pwr;
    ctrl == 8'h58 && second_connector_pair == 8'hFC && first_connector_pair == 8'hFC;
  endsequence
  property p_hpd;
    $past(rst_b) |->
      hotplug_level == ($past(ctrl.hotplug_pin_enable_n) ? 1'b0 : $past(hotplug_input_pin));
  endproperty
  a_powerup_vals: assert property ($rose(rst_b) |-> s_pwr)
    else $error("power-up values wrong");
  a_ctrl_on_ack: assert property ($changed(ctrl) |-> s_ack)
    else $error("control byte changed outside a write");
  a_second_on_ack: assert property ($changed(second_connector_pair) |-> s_ack)
    else $error("second pair byte changed outside a write");
  a_first_on_ack: assert property ($changed(first_connector_pair) |-> s_ack)
    else $error("first pair byte changed outside a write");
  a_aux_follow: assert property ($past(rst_b) |->
    aux_mux_enable == !$past(ctrl.aux_mux_enable_n))
    else $error("aux enable does not follow control bit 1");
  a_hpd_gate: assert property (p_hpd)
    else $error("hot-plug level gating wrong");
  a_hpd_ignored: assert property (
    ctrl.hotplug_pin_enable_n [*2] |-> hotplug_level == 1'b0)
    else $error("hot-plug pin not ignored");
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("data line driven high");
endmodule

// file: sim/rdc_regs_test.sv
// Self-checking bench for the configuration byte bank
`timescale 1ns/1ns
`include "rdc_cfg.svh"
module rdc_regs_test
  import rdc_pkg::*;
;
  localparam logic [7:0] AW = {`RDC_DEV_ADDR_DEFAULT, 1'b0};
  logic         mclk, rst_b, scl, sda_low, sda_out, sda_oe, hpl, aux, a;
  logic         pin = 1'b0;
  logic         pin_d;
  logic [7:0]   pa, pb, rd_val, b, q[$];
  logic [23:0]  d;
  logic [31:0]  lf = 32'h557B0A67;
  int           n_errors = 0, tests_run = 0;
  rdc_ctrl_type ctrl;
  event         rd_done;
  wire          sda = !(sda_low | sda_oe);
  rdc_regs u_rdc_regs (.mclk, .rst_b, .scl, .sda_in(sda), .sda_out, .sda_oe,
    .hotplug_input_pin(pin), .hotplug_level(hpl), .second_connector_pair(pa),
    .first_connector_pair(pb), .ctrl, .aux_mux_enable(aux));
  rdc_host u_rdc_host (.mclk, .sda, .scl, .sda_low);
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    lf <= nx(lf);
    pin <= lf[0];
  end
  always @(posedge mclk) begin
    pin_d <= pin;
  end
  task automatic end_of_test();
    $display("tests_run %0d n_errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (6) @(negedge mclk);
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
  endtask
  task automatic wr(input logic [7:0] p, input logic [23:0] v, input int n);
    u_rdc_host.start();
    u_rdc_host.wbyte(AW, a);
    u_rdc_host.wbyte(p, a);
    for (int i = 0; i < n; i++) begin
      u_rdc_host.wbyte(v[23-8*i -: 8], a);
      chk({7'h00, a}, 8'h01);
    end
    u_rdc_host.stop();
  endtask
  task automatic rd(input logic [7:0] p, input logic [23:0] e, input int n);
    u_rdc_host.start();
    u_rdc_host.wbyte(AW, a);
    u_rdc_host.wbyte(p, a);
    u_rdc_host.start();
    u_rdc_host.wbyte(AW | 8'h01, a);
    for (int i = 0; i < n; i++) begin
      q.push_back(e[23-8*i -: 8]);
      u_rdc_host.rbyte(i == n - 1, rd_val);
      -> rd_done;
    end
    u_rdc_host.stop();
  endtask
  initial forever begin
    @(rd_done);
    chk(rd_val, q.pop_front());
  end
  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    end_of_test();
  end
  initial begin
    do_reset();
    rd(8'h0A, 24'hFCFC58, 3);
    $display("power-up test done");
    d = lf[23:0];
    wr(8'h0A, d, 3);
    rd(8'h0A, d, 3);
    chk(ctrl, d[7:0]);
    $display("burst test done");
    for (int c = 0; c < 4; c++) begin
      b = {c[1:0], lf[5:3], c[0], c[1], lf[0]};
      wr(8'h0C, {b, 16'h0000}, 1);
      rd(8'h0C, {b, 16'h0000}, 1);
      chk({7'h00, aux}, {7'h00, ~b[1]});
      chk({7'h00, hpl}, {7'h00, pin_d & ~b[2]});
      chk({7'h00, sda_out}, 8'h00);
    end
    $display("threshold test done");
    wr(8'h0D, lf[23:0], 3);
    wr(8'h1F, lf[31:8], 1);
    rd(8'h0D, 24'h000000, 3);
    rd(8'h1F, 24'h000000, 1);
    $display("reserved test done");
    u_rdc_host.start();
    u_rdc_host.wbyte(AW ^ 8'h02, a);
    u_rdc_host.wbyte(8'h0C, a);
    u_rdc_host.wbyte(~b, a);
    u_rdc_host.stop();
    chk({7'h00, a}, 8'h00);
    chk(ctrl, b);
    $display("foreign address test done");
    do_reset();
    rd(8'h0A, 24'hFCFC58, 3);
    $display("second reset test done");
    end_of_test();
  end
endmodule
bind rdc_regs rdc_regs_assertions u_rdc_regs_assertions (.mclk, .rst_b, .scl, .sda_in,
  .sda_out, .sda_oe, .hotplug_input_pin, .hotplug_level, .second_connector_pair,
  .first_connector_pair, .ctrl, .aux_mux_enable);
